// [hw/external_memory_bus_strobes.v]
// External memory bus sequencer: address/data strobes, read/write and port drivers
//
// Overview of operation
// - ROM disable low fetches program externally
// - ROM disable high runs from internal ROM
// - Data strobe asserted once per transfer
// - Write data valid when data strobe falls
// - Address strobe pulses at transfer start
// - Address held valid at address strobe rise
// - Address driven out on ports zero, one
// - Bus release tri-states strobes and port zero; port one ignores release, driven to the end of a write, dropped before the read data phase
// - Read/write low on writes, high reads
// - Port one multiplexes address then data
// - Internal_rom_disable_n reset gives upper address, extended timing
// - Memory select low data, high program
`timescale 1ns/1ps
`include "ext_bus_defines.vh"
module external_memory_bus_strobes (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Straps
    input wire internal_rom_disable_n,
    // Core request side
    input wire req_valid,
    input wire req_write,
    input wire req_data_space,
    input wire [15:0] req_addr,
    input wire [7:0] req_wdata,
    input wire bus_release,
    input wire ext_timing_clear,
    input wire dm_select_enable,
    output reg req_ready,
    output reg rd_valid,
    output reg [7:0] rd_data,
    output reg rom_internal_active,
    // Bus pins
    output reg addr_latch_strobe_n,
    output reg addr_latch_strobe_oe,
    output reg mem_data_strobe_n,
    output reg mem_data_strobe_oe,
    output reg read_write_n,
    output reg read_write_oe,
    output reg [7:0] port0_out,
    output reg port0_oe,
    input wire [7:0] port1_in,
    output reg [7:0] port1_out,
    output reg port1_oe,
    output reg port3_bit4
);
    localparam S_IDLE = 4'b0001;
    localparam S_ADDR = 4'b0010;
    localparam S_HOLD = 4'b0100;
    localparam S_DATA = 4'b1000;

    reg rom_dis_meta_reg;
    reg rom_dis_sync_reg;
    reg [7:0] p1_meta_reg;
    reg [7:0] p1_sync_reg;
    reg rel_meta_reg;
    reg rel_sync_reg;
    reg [1:0] strap_age_reg;
    reg [3:0] state_reg;
    reg [2:0] cnt_reg;
    reg ext_timing_reg;
    reg straps_taken_reg;
    reg wr_reg;
    reg dspace_reg;
    reg [15:0] addr_reg;
    reg [7:0] wdata_reg;
    wire bus_drive = ~rel_sync_reg;
    wire [2:0] data_len = ext_timing_reg ? `DATA_PHASE_EXTENDED : `DATA_PHASE_NORMAL;
    // Strobe stays low one cycle past the data phase so the synchronised port holds settled data
    wire ds_end = (state_reg == S_DATA) && (cnt_reg == data_len + 3'h1);

    // Strap synchroniser
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rom_dis_meta_reg <= 1'b1;
            rom_dis_sync_reg <= 1'b1;
        end else begin
            rom_dis_meta_reg <= internal_rom_disable_n;
            rom_dis_sync_reg <= rom_dis_meta_reg;
        end
    end

    // Port one input synchroniser
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p1_meta_reg <= 8'h00;
            p1_sync_reg <= 8'h00;
        end else begin
            p1_meta_reg <= port1_in;
            p1_sync_reg <= p1_meta_reg;
        end
    end

    // Bus release synchroniser
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rel_meta_reg <= 1'b0;
            rel_sync_reg <= 1'b0;
        end else begin
            rel_meta_reg <= bus_release;
            rel_sync_reg <= rel_meta_reg;
        end
    end

    // Strap is taken only once the synchroniser shows the pin, not its reset value
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_age_reg <= 2'h0;
            straps_taken_reg <= 1'b0;
            rom_internal_active <= 1'b1;
            ext_timing_reg <= 1'b0;
        end else begin
            strap_age_reg <= {strap_age_reg[0], 1'b1};
            if (strap_age_reg[1] && !straps_taken_reg) begin
                straps_taken_reg <= 1'b1;
                rom_internal_active <= rom_dis_sync_reg;
                ext_timing_reg <= ~rom_dis_sync_reg & `RESET_EXT_TIMING_INTERNAL_ROM_DISABLE_N;
            end else if (ext_timing_clear) begin
                ext_timing_reg <= 1'b0;
            end
        end
    end

    // Pin drivers follow the synchronised release request
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_latch_strobe_oe <= 1'b0;
            mem_data_strobe_oe <= 1'b0;
            read_write_oe <= 1'b0;
            port0_oe <= 1'b0;
        end else begin
            addr_latch_strobe_oe <= bus_drive;
            mem_data_strobe_oe <= bus_drive;
            read_write_oe <= bus_drive;
            port0_oe <= bus_drive & (~rom_internal_active | state_reg != S_IDLE);
        end
    end

    // Read data taken from the synchronised port as the data strobe rises
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            rd_valid <= 1'b0;
            if (ds_end && !wr_reg) begin
                rd_data <= p1_sync_reg;
                rd_valid <= 1'b1;
            end
        end
    end

    // Transfer sequencer
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            cnt_reg <= 3'h0;
            wr_reg <= 1'b0;
            dspace_reg <= 1'b0;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            req_ready <= 1'b0;
            addr_latch_strobe_n <= 1'b1;
            mem_data_strobe_n <= 1'b1;
            read_write_n <= 1'b1;
            port0_out <= 8'h00;
            port1_out <= 8'h00;
            port1_oe <= 1'b0;
            port3_bit4 <= 1'b1;
        end else begin
            req_ready <= straps_taken_reg & bus_drive & (state_reg == S_IDLE) & ~req_valid;
            case (state_reg)
                S_IDLE: begin
                    addr_latch_strobe_n <= 1'b1;
                    mem_data_strobe_n <= 1'b1;
                    read_write_n <= 1'b1;
                    port1_oe <= 1'b0;
                    if (req_valid && req_ready) begin
                        wr_reg <= req_write;
                        dspace_reg <= req_data_space;
                        addr_reg <= req_addr;
                        wdata_reg <= req_wdata;
                        port0_out <= req_addr[15:8];
                        port1_out <= req_addr[7:0];
                        port1_oe <= 1'b1;
                        read_write_n <= ~req_write;
                        port3_bit4 <= dm_select_enable ? ~req_data_space : 1'b1;
                        addr_latch_strobe_n <= 1'b0;
                        req_ready <= 1'b0;
                        cnt_reg <= 3'h0;
                        state_reg <= S_ADDR;
                    end
                end
                S_ADDR: begin
                    addr_latch_strobe_n <= 1'b1;
                    port0_out <= addr_reg[15:8];
                    state_reg <= S_HOLD;
                end
                S_HOLD: begin
                    if (wr_reg) begin
                        port1_out <= wdata_reg;
                    end else begin
                        port1_oe <= 1'b0;
                    end
                    port3_bit4 <= dm_select_enable ? ~dspace_reg : 1'b1;
                    state_reg <= S_DATA;
                    cnt_reg <= 3'h0;
                end
                S_DATA: begin
                    if (cnt_reg == 3'h0) begin
                        mem_data_strobe_n <= 1'b0;
                    end
                    cnt_reg <= cnt_reg + 3'h1;
                    if (ds_end) begin
                        mem_data_strobe_n <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// [hw/ext_bus_defines.vh]
// Constants for the external memory bus strobe sequencer
`ifndef EXT_BUS_DEFINES_VH
`define EXT_BUS_DEFINES_VH
`define ADDR_PHASE_CYCLES 2'h1
`define DATA_PHASE_NORMAL 3'h2
`define DATA_PHASE_EXTENDED 3'h4
`define RESET_EXT_TIMING_INTERNAL_ROM_DISABLE_N 1'b1
`define RESET_DM_SELECT 1'b0
`endif

// [verification/ext_mem_model.sv]
// Behavioural external memory answering the sequencer strobes
`timescale 1ns/1ps
module ext_mem_model (
    // Bus pins
    input wire mem_data_strobe_n, addr_latch_strobe_n, read_write_n, port1_oe,
    input wire [7:0] port1_out,
    output reg [7:0] port1_in
);
    reg [7:0] mem [0:255];
    reg [7:0] addr = 8'h00;
    integer k;
    initial for (k = 0; k < 256; k++) mem[k] = 8'h00;
    always @(posedge addr_latch_strobe_n) addr <= port1_out;
    always @(negedge mem_data_strobe_n) if (!read_write_n) mem[addr] <= port1_out;
    // Undriven bus shows the inverse so stale data cannot pass
    always @* port1_in = (!mem_data_strobe_n && !port1_oe) ? mem[addr] : ~mem[addr];
endmodule

// [verification/ext_bus_chk.sv]
// Strobe timing checks for the external memory bus sequencer
`timescale 1ns/1ps
module ext_bus_chk (
    // Watched ports
    input wire clk, rstn, req_valid, req_ready, req_write, req_data_space, bus_release, dm_select_enable, rd_valid,
    input wire [15:0] req_addr,
    input wire [7:0] req_wdata, port0_out, port1_out,
    input wire addr_latch_strobe_n, mem_data_strobe_n, read_write_n, port1_oe, addr_latch_strobe_oe, port3_bit4
);
    reg [25:0] cap;
    always @(posedge clk or negedge rstn)
        if (!rstn) cap <= 26'h0000000;
        else if (req_valid && req_ready) cap <= {req_write, req_data_space, req_addr, req_wdata};
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_take; req_valid && req_ready; endsequence
    sequence s_as_pulse; !addr_latch_strobe_n ##1 addr_latch_strobe_n; endsequence
    chk_idle_high: assert property (req_ready |-> addr_latch_strobe_n && mem_data_strobe_n && read_write_n)
        else $error("idle level");
    chk_as_pulse: assert property (s_take |=> s_as_pulse) else $error("as pulse");
    chk_as_first: assert property ($fell(mem_data_strobe_n) |-> $past(addr_latch_strobe_n, 2))
        else $error("as order");
    chk_ds_once: assert property (s_take |-> ##[3:6] $fell(mem_data_strobe_n) ##1 (!$fell(mem_data_strobe_n))[*5])
        else $error("ds count");
    chk_rw_level: assert property (!mem_data_strobe_n |-> read_write_n == !cap[25]) else $error("rw");
    chk_dm_level: assert property (!mem_data_strobe_n && dm_select_enable |-> port3_bit4 == !cap[24])
        else $error("dm");
    chk_wr_data: assert property ($fell(mem_data_strobe_n) && !read_write_n |-> port1_oe && port1_out == cap[7:0])
        else $error("wdata");
    chk_addr_out: assert property ($rose(addr_latch_strobe_n) |-> {port0_out, port1_out} == cap[23:8])
        else $error("addr");
    chk_rd_answer: assert property ((s_take and !req_write) |-> ##[7:9] rd_valid) else $error("rd");
    chk_release: assert property (bus_release [*4] |-> !port1_oe && !addr_latch_strobe_oe) else $error("rel");
endmodule
bind external_memory_bus_strobes ext_bus_chk u_ext_bus_chk (
    .clk(clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_data_space(req_data_space), .bus_release(bus_release), .dm_select_enable(dm_select_enable),
    .rd_valid(rd_valid), .req_addr(req_addr), .req_wdata(req_wdata), .port0_out(port0_out),
    .port1_out(port1_out), .addr_latch_strobe_n(addr_latch_strobe_n), .mem_data_strobe_n(mem_data_strobe_n),
    .read_write_n(read_write_n), .port1_oe(port1_oe), .addr_latch_strobe_oe(addr_latch_strobe_oe),
    .port3_bit4(port3_bit4)
);

// [verification/tb_top.sv]
// Self-checking bench for the external memory bus sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; $display("Error %0t %h %h", $time, a, b); end end
module tb_top;
    reg clk = 0, rstn = 0, internal_rom_disable_n = 1, req_valid = 0, req_write = 0, req_data_space = 0;
    reg bus_release = 0, ext_timing_clear = 0, dm_select_enable = 1;
    reg [15:0] req_addr = 16'h0000;
    reg [7:0] req_wdata = 8'h00;
    wire req_ready, rd_valid, rom_internal_active, addr_latch_strobe_n, addr_latch_strobe_oe, mem_data_strobe_n;
    wire mem_data_strobe_oe, read_write_n, read_write_oe, port0_oe, port1_oe, port3_bit4;
    wire [7:0] rd_data, port0_out, port1_in, port1_out;
    int miscompares = 0, samples_checked = 0, n, i;
    always #25 clk = ~clk;
    external_memory_bus_strobes u_external_memory_bus_strobes (.*);
    ext_mem_model u_ext_mem_model (.*);
    task results;
        if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task do_reset(input s);
        rstn = 0;
        internal_rom_disable_n = s;
        repeat (12) @(posedge clk);
        #1 rstn = 1;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // One transfer; c counts edges from take to read answer
    task xfer(input w, input s, input [15:0] a, input [7:0] d, output int c);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 50) begin @(posedge clk); #1; k++; end
        {req_valid, req_write, req_data_space, req_addr, req_wdata} = {1'b1, w, s, a, d};
        @(posedge clk);
        #1 req_valid = 0;
        c = 0;
        while (!w && rd_valid !== 1'b1 && c < 50) begin @(posedge clk); #1; c++; end
        if (k == 50 || c == 50) begin miscompares++; results; end
    endtask
    task t_rom_mode;
        do_reset(1);
        `CHK(rom_internal_active, 1'b1)
        for (i = 0; i < 2; i++) begin
            xfer(1, i[0], 16'h12A0 + i[15:0], 8'hA5 ^ i[7:0], n);
            xfer(0, i[0], 16'h12A0 + i[15:0], 8'h00, n);
            `CHK(rd_data, 8'hA5 ^ i[7:0])
            `CHK(n, 6)
        end
    endtask
    task t_release;
        bus_release = 1;
        repeat (4) @(posedge clk);
        #1 `CHK({port1_oe, port0_oe, addr_latch_strobe_oe, mem_data_strobe_oe, read_write_oe, req_ready}, 6'h00)
        bus_release = 0;
    endtask
    task t_internal_rom_disable_n;
        do_reset(0);
        `CHK({rom_internal_active, port0_oe}, 2'b01)
        xfer(0, 0, 16'h12A0, 8'h00, n);
        `CHK(n, 8)
        `CHK(rd_data, 8'hA5)
        ext_timing_clear = 1;
        @(posedge clk);
        #1 ext_timing_clear = 0;
        xfer(0, 0, 16'h12A1, 8'h00, n);
        `CHK(n, 6)
        `CHK(rd_data, 8'hA4)
    endtask
    initial begin
        t_rom_mode;
        t_release;
        t_internal_rom_disable_n;
        results;
    end
endmodule
